/* core/servo_hub_pkg.sv */
package servo_hub_pkg;
  localparam int CLK_MHZ = 250;
  localparam int US_PER_MS_DOC = 1000;
  localparam int LONG_TMO_MS = 150;
  localparam int SHORT_TMO_MS = 80;
  localparam int RX_ALARM_MS = 1000;
  localparam int TEMP_LO_C = 70;
  localparam int TEMP_HI_C = 90;
  localparam int RX_N = 3;
  localparam int CH_W = 3;
  localparam int CAP_SH = 16;
  localparam int DIV_STEPS = 7;
  localparam int WORD_B = 4;
  localparam int OUT_STRIDE = 16;
  localparam int W_CFG = 0;
  localparam int W_TRIM = 1;
  localparam int W_LIM = 2;
  localparam logic [7:0]  PCT_FULL     = 8'h64;
  localparam logic [15:0] CENTER_US    = 16'h05dc;
  localparam logic [15:0] GROUP_GAP_US = 16'h09c4;
  localparam logic [15:0] RST_DELAY_MS = 16'h0064;
  localparam logic [15:0] RST_LO_US    = 16'h03e8;
  localparam logic [15:0] RST_HI_US    = 16'h07d0;
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_PERIOD = 8'h04;
  localparam logic [7:0] A_CAPL   = 8'h08;
  localparam logic [7:0] A_CURL   = 8'h0c;
  localparam logic [7:0] A_VOLL   = 8'h10;
  localparam logic [7:0] A_AEN    = 8'h14;
  localparam logic [7:0] A_STAT   = 8'h18;
  localparam logic [7:0] A_VMM    = 8'h1c;
  localparam logic [7:0] A_CMAX   = 8'h20;
  localparam logic [7:0] A_TMM    = 8'h24;
  localparam logic [7:0] A_CAP    = 8'h28;
  localparam logic [7:0] A_OVL    = 8'h2c;
  localparam logic [7:0] A_AVAIL  = 8'h30;
  localparam logic [7:0] A_CLEAR  = 8'h38;
  localparam logic [7:0] A_OUT    = 8'h40;
  typedef enum logic [1:0] {ST_LONG, ST_SHORT, ST_MIX} strat_t;
  typedef enum logic [1:0] {M_SERVO, M_DOUT, M_DIN, M_BUSOUT} mode_t;
  typedef enum logic [1:0] {L_HOLD, L_OFF, L_PRESET} lmode_t;
  typedef enum logic [1:0] {D_REPEAT, D_ONE, D_ZERO} dlvl_t;
  typedef enum logic [1:0] {LS_OK, LS_DELAY, LS_LOST} loss_t;
  typedef struct packed {
    logic [15:0] delay;
    strat_t      strat;
    logic        prot;
  } ctrl_t;
  typedef struct packed {
    logic hot;
    logic rx;
    logic ovl;
    logic temp;
  } aen_t;
  typedef struct packed {
    dlvl_t            dlvl;
    logic [1:0]       grp;
    lmode_t           lmode;
    mode_t            mode;
    logic             rev;
    logic [CH_W-1:0]  ch;
  } ocfg_t;
  typedef struct packed {
    ocfg_t       c;
    logic [15:0] rate;
    logic [15:0] trim;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] thr;
    logic [15:0] preset;
  } out_t;
  typedef struct packed {
    logic            valid;
    logic            frame;
    logic [CH_W-1:0] chan;
    logic [15:0]     pos;
  } rx_pkt_t;
  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] cur;
    logic [15:0] temp;
  } meas_t;
  typedef struct packed {
    logic cap;
    logic cur;
    logic volt;
    logic temp;
    logic ovl;
    logic rx;
  } alarm_t;
endpackage

/* core/servo_hub_failover_control.sv */
// Functional notes
// RULE_01: protection off: loss stops all servo pulses
// RULE_02: protection on: per-output loss response applies
// RULE_03: repeat last input for delay, then respond
// RULE_04: pulse period programmable, default frame-synchronous
// RULE_05: long strategy switches after 150ms absence
// RULE_06: short strategy switches after 80ms absence
// RULE_07: mixing merges active receivers, native bus only
// RULE_08: serial bus outputs always use long switchover
// RULE_09: loss response: hold, no pulses, or preset
// RULE_10: preset move limited by per-output rate
// RULE_11: outputs clamped between upper and lower limit; the loss preset path is not clamped
// RULE_12: per-output trim, reversal and channel assignment
// RULE_13: same group outputs pulse at once
// RULE_14: digital out: below threshold 0, else 1
// RULE_15: digital out on loss: keep, one or zero
// RULE_16: capacity, current, voltage alarms; zero level disables
// RULE_17: overheat alarm above 70 or 90 degrees
// RULE_18: receiver alarm after 1s without primary data
// RULE_19: record voltage, current, temperature extremes
// RULE_20: per-receiver availability as percentage of runtime
// RULE_21: per-output overload now flag and session flag
// RULE_22: overload alarm when enabled and output overloaded
// RULE_23: clear resets extremes and capacity at once
// RULE_24: digital input pin reports its level
`timescale 1ns/1ps
`default_nettype none
module servo_hub_failover_control
  import servo_hub_pkg::*;
#(
  parameter int NO        = 8,
  parameter int US_PER_MS = US_PER_MS_DOC
)
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire rx_pkt_t [RX_N-1:0]   rx_i,
  input  wire logic [RX_N-1:0]      rx_native_i,
  input  wire meas_t                meas_i,
  input  wire logic                 clear_i,
  input  wire logic [NO-1:0]        ovl_i,
  input  wire logic [NO-1:0]        pin_i,
  output logic      [NO-1:0]        pin_o,
  output logic      [NO-1:0]        pin_oe_o,
  output logic      [NO-1:0]        din_o,
  output alarm_t                    alarm_o,
  output logic      [1:0]           act_rx_o,
  output logic      [1:0]           bus_rx_o
);
  localparam int NCH = 1 << CH_W;
  localparam int CYC_US = CLK_MHZ;

  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdat;
    ctrl_t                     ctrl;
    logic [15:0]               per;
    logic [15:0]               capl;
    logic [15:0]               curl;
    logic [15:0]               voll;
    aen_t                      aen;
    out_t [NO-1:0]             o;
    logic [NCH-1:0][15:0]      chan;
    logic [RX_N-1:0][10:0]     age;
    logic [1:0]                sel;
    logic [1:0]                bsel;
    loss_t                     ls;
    logic [15:0]               lms;
    logic [7:0]                ucnt;
    logic [15:0]               mcnt;
    logic [15:0]               tus;
    logic [15:0]               pcnt;
    logic [NO-1:0][15:0]       cur;
    logic [NO-1:0]             dout;
    logic [NO-1:0]             pin;
    logic [NO-1:0]             ov1;
    logic [NO-1:0]             ov2;
    logic [NO-1:0]             ovh;
    logic [NO-1:0]             di1;
    logic [NO-1:0]             di2;
    logic [15:0]               vmin;
    logic [15:0]               vmax;
    logic [15:0]               cmax;
    logic [15:0]               tmin;
    logic [15:0]               tmax;
    logic [31:0]               cap;
    logic [23:0]               tot;
    logic [RX_N-1:0][23:0]     av;
    logic [RX_N-1:0][7:0]      pct;
    logic [1:0]                dr;
    logic [2:0]                dk;
    logic [30:0]               rem;
    logic [6:0]                q;
    alarm_t                    al;
  } st_t;

  st_t                 s;
  st_t                 n;
  logic                us;
  logic                ms;
  logic                lost;
  logic                stop;
  logic                expd;
  logic                mixok;
  logic                strt;
  logic                acc;
  logic                wr;
  logic                clr;
  logic                oreg;
  logic                qb;
  logic [RX_N-1:0]     act;
  logic [RX_N-1:0]     actl;
  logic [10:0]         tmo;
  logic [16:0]         st;
  logic [30:0]         dv;
  logic [15:0]         rv;
  logic [NO-1:0][15:0] pos;
  logic [NO-1:0]       lvl;
  logic [NO-1:0]       smask;
  int                  oi;
  int                  wd;

  function automatic logic [31:0] wm(input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < WORD_B; b++)
    begin
      if (wb_sel_i[b])
        r[b*8 +: 8] = wb_dat_i[b*8 +: 8];
    end
    return r;
  endfunction

  assign acc = wb_cyc_i && wb_stb_i && !s.ack;
  assign wr  = acc && wb_we_i;
  assign oi  = (int'(wb_adr_i) - int'(A_OUT)) / OUT_STRIDE;
  assign wd  = (int'(wb_adr_i) % OUT_STRIDE) / WORD_B;
  assign oreg = (wb_adr_i >= A_OUT) && (oi < NO);

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = s;
    st = '0;
    rv = '0;
    dv = '0;
    qb = 1'b0;
    n.ack = acc;
    us = s.ucnt == 8'(CYC_US - 1);
    ms = us && (s.mcnt == 16'(US_PER_MS - 1));
    n.ucnt = us ? 8'h00 : s.ucnt + 8'h01;
    if (us)
      n.mcnt = ms ? 16'h0000 : s.mcnt + 16'h0001;
    mixok = (s.ctrl.strat == ST_MIX) && (&rx_native_i); // [RULE_07]
    tmo = (s.ctrl.strat == ST_SHORT) ? 11'(SHORT_TMO_MS) : 11'(LONG_TMO_MS); // [RULE_05] [RULE_06]
    for (int r = 0; r < RX_N; r++)
    begin
      act[r] = s.age[r] <= tmo;
      actl[r] = s.age[r] <= 11'(LONG_TMO_MS); // [RULE_08]
      if (rx_i[r].valid)
        n.age[r] = '0;
      else if (ms && s.age[r] != '1)
        n.age[r] = s.age[r] + 11'h001;
      // mixing takes every active receiver's packet; otherwise only the chosen one
      if (rx_i[r].valid && (mixok ? act[r] : (2'(r) == s.sel))) // [RULE_07]
        n.chan[rx_i[r].chan] = rx_i[r].pos;
    end
    // descending so the nearest next receiver wins
    for (int k = RX_N - 1; k >= 1; k--)
    begin
      if (!act[s.sel] && act[(int'(s.sel) + k) % RX_N]) // [RULE_05] [RULE_06]
        n.sel = 2'((int'(s.sel) + k) % RX_N);
      if (!actl[s.bsel] && actl[(int'(s.bsel) + k) % RX_N]) // [RULE_08]
        n.bsel = 2'((int'(s.bsel) + k) % RX_N);
    end
    lost = ~|act;
    case (s.ls)
      LS_OK:
      begin
        if (lost)
        begin
          n.ls = LS_DELAY;
          n.lms = '0;
        end
      end
      LS_DELAY:
      begin
        if (!lost)
          n.ls = LS_OK;
        else if (s.lms >= s.ctrl.delay) // [RULE_03]
          n.ls = LS_LOST;
        else if (ms)
          n.lms = s.lms + 16'h0001;
      end
      LS_LOST:
      begin
        if (!lost)
          n.ls = LS_OK;
      end
      default: n.ls = LS_OK;
    endcase
    stop = !s.ctrl.prot && (lost || s.ls != LS_OK); // [RULE_01]
    expd = s.ctrl.prot && (s.ls == LS_LOST); // [RULE_02] [RULE_03]
    // period zero follows the chosen receiver's frame timing
    strt = (s.per == '0) ? rx_i[s.sel].frame : (us && s.pcnt >= s.per - 16'h0001); // [RULE_04]
    if (strt)
    begin
      n.tus = '0;
      n.pcnt = '0;
    end
    else if (us)
    begin
      if (s.tus != '1)
        n.tus = s.tus + 16'h0001;
      n.pcnt = s.pcnt + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    for (int i = 0; i < NO; i++)
    begin
      rv = s.chan[s.o[i].c.ch]; // [RULE_12]
      if (s.o[i].c.rev)
        rv = CENTER_US + CENTER_US - rv; // [RULE_12]
      lvl[i] = rv >= s.o[i].thr; // [RULE_14]
      pos[i] = rv + s.o[i].trim; // [RULE_12]
      if (pos[i] > s.o[i].hi)
        pos[i] = s.o[i].hi; // [RULE_11]
      if (pos[i] < s.o[i].lo)
        pos[i] = s.o[i].lo; // [RULE_11]
      if (expd && s.o[i].c.lmode == L_PRESET)
      begin
        // zero rate jumps at once; else one step per ms
        if (s.o[i].rate == '0)
          n.cur[i] = s.o[i].preset; // [RULE_09]
        else if (ms && s.cur[i] < s.o[i].preset)
          n.cur[i] = (s.o[i].preset - s.cur[i] > s.o[i].rate) ?
                     s.cur[i] + s.o[i].rate : s.o[i].preset; // [RULE_10]
        else if (ms)
          n.cur[i] = (s.cur[i] - s.o[i].preset > s.o[i].rate) ?
                     s.cur[i] - s.o[i].rate : s.o[i].preset; // [RULE_10]
      end
      else
        n.cur[i] = pos[i]; // hold comes free: channels freeze while lost [RULE_09]
      if (expd)
      begin
        case (s.o[i].c.dlvl)
          D_ONE:   n.dout[i] = 1'b1; // [RULE_15]
          D_ZERO:  n.dout[i] = 1'b0; // [RULE_15]
          default: n.dout[i] = s.dout[i]; // [RULE_15]
        endcase
      end
      else if (!stop)
        n.dout[i] = lvl[i]; // [RULE_14]
      st = 17'(s.o[i].c.grp) * 17'(GROUP_GAP_US); // [RULE_13]
      case (s.o[i].c.mode)
        M_SERVO: n.pin[i] = !(stop || (expd && s.o[i].c.lmode == L_OFF)) &&
                            ({1'b0, s.tus} >= st) &&
                            ({1'b0, s.tus} < st + {1'b0, s.cur[i]}); // [RULE_01] [RULE_09] [RULE_13]
        M_DOUT:  n.pin[i] = s.dout[i]; // [RULE_14]
        default: n.pin[i] = 1'b0;
      endcase
    end
    n.ov1 = ovl_i;
    n.ov2 = s.ov1;
    n.ovh = s.ovh | s.ov2; // [RULE_21]
    n.di1 = pin_i;
    n.di2 = s.di1; // [RULE_24]
    ////////////////////////////////////////////////////////////////////////
    if (meas_i.volt < s.vmin)
      n.vmin = meas_i.volt; // [RULE_19]
    if (meas_i.volt > s.vmax)
      n.vmax = meas_i.volt; // [RULE_19]
    if (meas_i.cur > s.cmax)
      n.cmax = meas_i.cur; // [RULE_19]
    if (meas_i.temp < s.tmin)
      n.tmin = meas_i.temp; // [RULE_19]
    if (meas_i.temp > s.tmax)
      n.tmax = meas_i.temp; // [RULE_19]
    if (ms)
      n.cap = s.cap + 32'(meas_i.cur);
    clr = clear_i || (wr && wb_adr_i == A_CLEAR);
    if (clr)
    begin
      n.vmin = '1; // [RULE_23]
      n.vmax = '0;
      n.cmax = '0;
      n.tmin = '1;
      n.tmax = '0;
      n.cap = '0;
    end
    n.al.cap = (s.capl != '0) && (s.cap[CAP_SH +: 16] > s.capl); // [RULE_16]
    n.al.cur = (s.curl != '0) && (meas_i.cur > s.curl); // [RULE_16]
    n.al.volt = (s.voll != '0) && (meas_i.volt < s.voll); // [RULE_16]
    n.al.temp = s.aen.temp &&
                (meas_i.temp > (s.aen.hot ? 16'(TEMP_HI_C) : 16'(TEMP_LO_C))); // [RULE_17]
    n.al.ovl = s.aen.ovl && (|s.ov2); // [RULE_22]
    n.al.rx = s.aen.rx && (s.age[0] > 11'(RX_ALARM_MS)); // [RULE_18]
    if (ms && s.tot != '1)
    begin
      n.tot = s.tot + 24'h000001; // [RULE_20]
      for (int r = 0; r < RX_N; r++)
        if (act[r])
          n.av[r] = s.av[r] + 24'h000001; // [RULE_20]
    end
    // shared serial divider, one quotient bit per cycle per receiver
    if (s.dk == '0)
    begin
      n.rem = 31'(s.av[s.dr]) * 31'(PCT_FULL); // [RULE_20]
      n.q = '0;
      n.dk = 3'(DIV_STEPS);
    end
    else
    begin
      dv = 31'(s.tot) << (s.dk - 3'h1);
      qb = s.rem >= dv;
      if (qb)
        n.rem = s.rem - dv;
      n.q[s.dk - 3'h1] = qb;
      n.dk = s.dk - 3'h1;
      if (s.dk == 3'h1)
      begin
        n.pct[s.dr] = (s.tot == '0) ? 8'h00 : {1'b0, n.q}; // [RULE_20]
        n.dr = (s.dr == 2'(RX_N - 1)) ? 2'h0 : s.dr + 2'h1;
      end
    end
    ////////////////////////////////////////////////////////////////////////
    if (acc)
    begin
      n.rdat = '0;
      case (wb_adr_i)
        A_CTRL:   n.rdat = 32'(s.ctrl);
        A_PERIOD: n.rdat = 32'(s.per);
        A_CAPL:   n.rdat = 32'(s.capl);
        A_CURL:   n.rdat = 32'(s.curl);
        A_VOLL:   n.rdat = 32'(s.voll);
        A_AEN:    n.rdat = 32'(s.aen);
        A_STAT:   n.rdat = 32'({s.al, s.ls, s.bsel, s.sel, act});
        A_VMM:    n.rdat = {s.vmax, s.vmin};
        A_CMAX:   n.rdat = 32'(s.cmax);
        A_TMM:    n.rdat = {s.tmax, s.tmin};
        A_CAP:    n.rdat = s.cap;
        A_OVL:    n.rdat = {16'(s.ovh), 16'(s.ov2)}; // [RULE_21]
        A_AVAIL:  n.rdat = 32'(s.pct); // [RULE_20]
        default:
        begin
          if (oreg)
          begin
            case (wd)
              W_CFG:   n.rdat = {s.cur[oi], 16'(s.o[oi].c)};
              W_TRIM:  n.rdat = {s.o[oi].rate, s.o[oi].trim};
              W_LIM:   n.rdat = {s.o[oi].hi, s.o[oi].lo};
              default: n.rdat = {s.o[oi].thr, s.o[oi].preset};
            endcase
          end
        end
      endcase
    end
    if (wr)
    begin
      case (wb_adr_i)
        A_CTRL:   n.ctrl = ctrl_t'(wm(32'(s.ctrl)) >> 0);
        A_PERIOD: n.per = 16'(wm(32'(s.per)));
        A_CAPL:   n.capl = 16'(wm(32'(s.capl)));
        A_CURL:   n.curl = 16'(wm(32'(s.curl)));
        A_VOLL:   n.voll = 16'(wm(32'(s.voll)));
        A_AEN:    n.aen = aen_t'(wm(32'(s.aen)) >> 0);
        default:
        begin
          if (oreg)
          begin
            case (wd)
              W_CFG:   n.o[oi].c = ocfg_t'(wm(32'(s.o[oi].c)) >> 0);
              W_TRIM:  {n.o[oi].rate, n.o[oi].trim} = wm({s.o[oi].rate, s.o[oi].trim});
              W_LIM:   {n.o[oi].hi, n.o[oi].lo} = wm({s.o[oi].hi, s.o[oi].lo});
              default: {n.o[oi].thr, n.o[oi].preset} = wm({s.o[oi].thr, s.o[oi].preset});
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.ctrl.delay <= RST_DELAY_MS;
      s.age <= '1;
      s.chan <= {NCH{CENTER_US}};
      s.vmin <= '1;
      s.tmin <= '1;
      for (int i = 0; i < NO; i++)
      begin
        s.o[i].lo <= RST_LO_US;
        s.o[i].hi <= RST_HI_US;
        s.o[i].preset <= CENTER_US;
        s.o[i].thr <= CENTER_US;
        s.cur[i] <= CENTER_US;
      end
    end
    else if (ce_i)
      s <= n;
  end

  always_comb
  begin
    for (int i = 0; i < NO; i++)
    begin
      smask[i] = s.o[i].c.mode == M_SERVO;
      // input pins stay undriven, the pad pull-up sets the open level
      pin_oe_o[i] = smask[i] || (s.o[i].c.mode == M_DOUT); // [RULE_24]
    end
  end

  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign pin_o    = s.pin;
  assign din_o    = s.di2;
  assign alarm_o  = s.al;
  assign act_rx_o = s.sel;
  assign bus_rx_o = s.bsel;

  ////////////////////////////////////////////////////////////////////////////
  a_loss_no_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
    (!s.ctrl.prot && s.ls != LS_OK && $past(!s.ctrl.prot) && $stable(smask))
    |-> ((s.pin & smask) == '0)) else $error("pulse during loss with protection off");
  a_delay_first: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
    $rose(s.ls == LS_LOST) |-> (s.lms >= s.ctrl.delay))
    else $error("loss response before delay");
  a_rx_switch: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05] [RULE_06]
    (ce_i && s.age[s.sel] > tmo && (|act)) |=> (s.sel != $past(s.sel)))
    else $error("no switch to active receiver");
  a_bus_long: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
    (ce_i && s.age[s.bsel] > 11'(LONG_TMO_MS) && (|actl)) |=> (s.bsel != $past(s.bsel)))
    else $error("bus output receiver not switched");
  a_travel_clamp: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_11]
    (s.ls == LS_OK && $past(s.ls == LS_OK) && $stable(s.o[0].lo) &&
     $stable(s.o[0].hi) && s.o[0].lo <= s.o[0].hi)
    |-> (s.cur[0] >= s.o[0].lo && s.cur[0] <= s.o[0].hi))
    else $error("output outside travel limits");
  a_dig_level: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_14]
    (ce_i && s.ls == LS_OK && !stop && s.o[0].c.mode == M_DOUT) ##1
    (ce_i && s.o[0].c.mode == M_DOUT)
    |=> (s.pin[0] == $past(lvl[0], 2))) else $error("digital level wrong");
  a_dig_loss_one: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_15]
    (ce_i && expd && s.o[0].c.dlvl == D_ONE) |=> s.dout[0])
    else $error("digital loss level not forced high");
  a_rx_alarm: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_18]
    (ce_i && s.aen.rx && s.age[0] > 11'(RX_ALARM_MS)) |=> s.al.rx)
    else $error("receiver alarm missing");
  a_ovl_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_21]
    (ce_i && s.ov2 != '0) |=> ((s.ovh & $past(s.ov2)) == $past(s.ov2)))
    else $error("session overload flag not set");
  a_clear_all: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_23]
    (ce_i && clr) |=> (s.cap == '0 && s.vmax == '0 && s.tmax == '0 && s.cmax == '0))
    else $error("clear did not reset statistics");
endmodule
`default_nettype wire

/* verif/rx_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_link_model
  import servo_hub_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic [RX_N-1:0] en_i,
  input  wire logic [15:0]     pos_i,
  output rx_pkt_t [RX_N-1:0]   rx_o
);
  logic [5:0]         tick_reg = 6'h00;
  rx_pkt_t [RX_N-1:0] rx_reg   = '0;
  assign rx_o = rx_reg;
  // one channel word per short frame keeps packet spacing well under a ms tick
  always @(posedge clk_i)
  begin
    tick_reg <= tick_reg + 6'h01;
    for (int i = 0; i < RX_N; i++)
    begin
      rx_reg[i].valid <= en_i[i] && tick_reg == 6'h00;
      rx_reg[i].frame <= en_i[i] && tick_reg == 6'h00;
      rx_reg[i].chan  <= '0;
      // between words the data lines toggle so stale data is never mistaken
      rx_reg[i].pos   <= (en_i[i] && tick_reg == 6'h00) ? pos_i : ~rx_reg[i].pos;
    end
  end
endmodule
`default_nettype wire

/* verif/test_servo_hub_failover_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_servo_hub_failover_control
  import servo_hub_pkg::*;
;
  localparam int NO      = 8;
  localparam int UPM     = 2;
  localparam int TMO_MIN = (SHORT_TMO_MS - 1) * UPM * CLK_MHZ;
  logic               clk, rst, cyc, stb, we, ack, clr;
  logic [7:0]         adr;
  logic [31:0]        wdat, rdat, q;
  logic [2:0]         en;
  logic [15:0]        pos;
  logic [NO-1:0]      ovl, pin, pin_oe, din;
  logic [1:0]         act, bsel;
  meas_t              meas;
  alarm_t             alarm;
  rx_pkt_t [RX_N-1:0] rx;
  int                 bad_count = 0;
  int                 checked = 0;
  int                 n;
  ////////////////////////////////////////////////////////////////////////
  servo_hub_failover_control #(.NO(NO), .US_PER_MS(UPM)) dut (
    .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_i(rx), .rx_native_i(3'b111), .meas_i(meas), .clear_i(clr),
    .ovl_i(ovl), .pin_i(pin | ~pin_oe), .pin_o(pin), .pin_oe_o(pin_oe), .din_o(din),
    .alarm_o(alarm), .act_rx_o(act), .bus_rx_o(bsel));
  rx_link_model rx_model (.clk_i(clk), .en_i(en), .pos_i(pos), .rx_o(rx));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 64);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 64)
    begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard; two 80 ms receiver timeouts dominate the run
  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    {rst, cyc, stb, we, clr, adr, wdat, en, ovl} = {5'h10, 8'h00, 32'h0, 3'h0, 8'h00};
    pos = CENTER_US;
    meas = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, A_CTRL, 32'h0);
    chk("ctrl reset", q, 32'h0000_0320);
    bus(1'b0, A_PERIOD, 32'h0);
    chk("period auto", q, 32'h0);
    bus(1'b1, A_PERIOD, 32'h0000_4e20);
    bus(1'b0, A_PERIOD, 32'h0);
    chk("period", q, 32'h0000_4e20);
    bus(1'b0, 8'h3c, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("servo drives pin", pin_oe[1], 1);
    chk("din servo low", din[1], 0);
    bus(1'b1, A_OUT + 8'h10, 32'h20);
    repeat (4) @(posedge clk);
    chk("din released", pin_oe[1], 0);
    chk("din pull-up", din[1], 1);
    meas.volt <= 16'h0f00;
    meas.temp <= 16'd71;
    bus(1'b1, A_VOLL, 32'h0000_1000);
    repeat (16) @(posedge clk);
    chk("volt alarm", alarm.volt, 1);
    bus(1'b1, A_VOLL, 32'h0);
    repeat (16) @(posedge clk);
    chk("volt off", alarm.volt, 0);
    bus(1'b1, A_AEN, 32'h5);
    repeat (16) @(posedge clk);
    chk("hot 70", alarm.temp, 1);
    chk("rx alarm", alarm.rx, 1);
    bus(1'b1, A_AEN, 32'h9);
    repeat (16) @(posedge clk);
    chk("hot 90", alarm.temp, 0);
    chk("rx alarm off", alarm.rx, 0);
    meas.cur <= 16'h0200;
    bus(1'b1, A_CURL, 32'h0000_0100);
    repeat (16) @(posedge clk);
    chk("cur alarm", alarm.cur, 1);
    meas.volt <= 16'h1000;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
    meas.volt <= 16'h1200;
    @(posedge clk);
    meas.volt <= 16'h0e00;
    repeat (4) @(posedge clk);
    bus(1'b0, A_VMM, 32'h0);
    chk("volt extremes", q, 32'h1200_0e00);
    bus(1'b0, A_CMAX, 32'h0);
    chk("cur max", q, 32'h0000_0200);
    bus(1'b1, A_AEN, 32'h2);
    ovl <= 8'h04;
    repeat (16) @(posedge clk);
    chk("ovl alarm", alarm.ovl, 1);
    ovl <= 8'h00;
    repeat (16) @(posedge clk);
    bus(1'b0, A_OVL, 32'h0);
    chk("ovl flags", q, 32'h0004_0000);
    bus(1'b1, A_OUT + 8'h0c, 32'h05dc_05dc);
    bus(1'b1, A_OUT, 32'h10);
    en <= 3'b011;
    pos <= 16'h0600;
    repeat (200) @(posedge clk);
    chk("dout high", pin[0], 1);
    pos <= 16'h0500;
    repeat (200) @(posedge clk);
    chk("dout low", pin[0], 0);
    bus(1'b1, A_OUT, 32'h18);
    repeat (200) @(posedge clk);
    chk("dout reversed", pin[0], 1);
    bus(1'b1, A_CTRL, 32'h0000_0323);
    repeat (200) @(posedge clk);
    chk("first rx", act, 2'd0);
    en <= 3'b010;
    n = 0;
    while (act !== 2'd1 && n < 60000)
    begin
      @(posedge clk);
      n++;
    end
    chk("switch late enough", n >= TMO_MIN, 1);
    chk("switched rx", act, 2'd1);
    chk("bus rx long", bsel, 2'd0);
    bus(1'b0, A_AVAIL, 32'h0);
    chk("avail rx0", q[7:0] >= 8'd90, 1);
    chk("avail rx1", q[15:8] >= 8'd90, 1);
    chk("avail rx2", q[23:16], 0);
    // 1 ms delay, short timeout, protection on; output 0 forced high on loss
    bus(1'b1, A_CTRL, 32'h0000_000b);
    bus(1'b1, A_OUT, 32'h418);
    pos <= 16'h0600;
    repeat (200) @(posedge clk);
    chk("dout reversed low", pin[0], 0);
    en <= 3'b000;
    repeat (39000) @(posedge clk);
    chk("no loss before timeout", pin[0], 0);
    repeat (4000) @(posedge clk);
    chk("loss level one", pin[0], 1);
    bus(1'b0, A_STAT, 32'h0);
    chk("loss state", q[8:7], 2'd2);
    chk("bus rx later", q[6:5], 2'd1);
    chk("no active rx", q[2:0], 3'd0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
